/* File: rtct_pkg.sv */
// constants and register map of the 16-bit rtc-capable timer
package rtct_pkg;
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_COUNT = 4'h4;
    localparam logic [3:0] ADDR_PERIOD = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    localparam logic [4:0] ADDR_MASK = 5'h10;
    localparam int BIT_RUN = 15;
    localparam int BIT_IDLE_STOP = 13;
    localparam int BIT_GATE = 6;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_SYNC = 2;
    localparam int BIT_SRC = 1;
    localparam logic [15:0] CONTROL_WMASK = 16'hA076;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    localparam int IRQ_PERIOD = 0;
    localparam int IRQ_GATE = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum {RTCT_TIMER, RTCT_GATED, RTCT_SYNC_CNT, RTCT_ASYNC_CNT} rtct_mode_t;
endpackage : rtct_pkg

/* File: rtct_prescale.sv */
// input prescaler dividing count pulses by 1, 8, 64 or 256
`timescale 1ns/10ps
module rtct_prescale (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic pulse_in,
    input wire logic [1:0] select,
    output logic pulse_out
);
    import rtct_pkg::*;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [7:0] limit;
    logic next_pulse;
    always_comb begin
        case (select)
            2'h3: limit = 8'hFF;
            2'h2: limit = 8'h3F;
            2'h1: limit = 8'h07;
            default: limit = 8'h00;
        endcase
        next_cnt = cnt;
        next_pulse = 1'b0;
        if (clear) begin
            next_cnt = 8'h00;
        end else if (pulse_in) begin
            if (cnt >= limit) begin
                next_cnt = 8'h00;
                next_pulse = 1'b1;
            end else begin
                next_cnt = cnt + 8'h01;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            pulse_out <= 1'b0;
        end else begin
            cnt <= next_cnt;
            pulse_out <= next_pulse;
        end
    end
endmodule : rtct_prescale

/* File: rtct_timer.sv */
// 16-bit timer/counter top with axi4-lite registers and interrupt
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
module rtct_timer (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic IDLE,
    input wire logic EXT_COUNT_PIN,
    input wire logic CRYSTAL_CLK,
    input wire logic [4:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [4:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic IRQ
);
    import rtct_pkg::*;
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    logic [15:0] timer_control;
    logic [15:0] count;
    logic [15:0] period_register;
    logic [1:0] status;
    logic [1:0] mask;
    logic aw_held;
    logic w_held;
    logic [4:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [15:0] next_control;
    logic [15:0] next_count;
    logic [15:0] next_period;
    logic [1:0] next_status;
    logic [1:0] next_mask;
    logic next_aw_held;
    logic next_w_held;
    logic [4:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_arready;
    logic next_irq;

    // sampled pins, previous levels for edge detection
    logic pin_q;
    logic xtal_q;
    logic gate_prev;
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic run_enable;
    logic idle_stop;
    logic gate_enable;
    logic ext_sync_select;
    logic clock_source_select;
    logic [1:0] prescale_select;
    rtct_mode_t mode;
    logic ext_rise;
    logic raw_pulse;
    logic ps_pulse;
    logic active;
    logic inc;
    logic gate_fall;
    logic period_hit;

    assign run_enable = timer_control[BIT_RUN];
    assign idle_stop = timer_control[BIT_IDLE_STOP];
    assign gate_enable = timer_control[BIT_GATE];
    assign ext_sync_select = timer_control[BIT_SYNC];
    assign clock_source_select = timer_control[BIT_SRC];
    assign prescale_select = timer_control[BIT_PS_HI:BIT_PS_LO];

    always_comb begin
        if (!clock_source_select) begin
            mode = gate_enable ? RTCT_GATED : RTCT_TIMER;
        end else begin
            mode = ext_sync_select ? RTCT_SYNC_CNT : RTCT_ASYNC_CNT;
        end
    end

    // crystal drives the pin path in rtc use
    assign ext_rise = (EXT_COUNT_PIN | CRYSTAL_CLK) & ~(pin_q | xtal_q);
    assign active = run_enable & ~(idle_stop & IDLE);
    always_comb begin
        case (mode)
            RTCT_TIMER: raw_pulse = active;
            RTCT_GATED: raw_pulse = active & EXT_COUNT_PIN;
            default: raw_pulse = active & ext_rise;
        endcase
    end

    rtct_prescale u_prescale (
        .clk(MCLK),
        .rst_n(rst_n),
        .clear(~run_enable),
        .pulse_in(raw_pulse),
        .select(prescale_select),
        .pulse_out(ps_pulse)
    );

    // sync select picks the two-stage path
    assign inc = (mode == RTCT_SYNC_CNT) ? (sync_b ^ sync_c) : ps_pulse;
    assign period_hit = inc & (count == period_register);
    assign gate_fall = (mode == RTCT_GATED) & run_enable & gate_prev & ~EXT_COUNT_PIN;

    always_comb begin
        next_count = count;
        next_status = status;
        next_control = timer_control;
        next_period = period_register;
        next_mask = mask;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = S_AXI_BVALID;
        next_bresp = S_AXI_BRESP;
        next_rvalid = S_AXI_RVALID;
        next_rdata = S_AXI_RDATA;
        next_rresp = S_AXI_RRESP;
        next_arready = 1'b0;
        if (period_hit) begin
            next_count = 16'h0000;
        end else if (inc) begin
            next_count = count + 16'h0001;
        end
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            next_aw_held = 1'b1;
            next_aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            next_w_held = 1'b1;
            next_w_data = S_AXI_WDATA;
            next_w_strb = S_AXI_WSTRB;
        end
        if (S_AXI_BVALID && S_AXI_BREADY) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !S_AXI_BVALID) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            if (aw_addr == {1'b0, ADDR_CONTROL}) begin
                if (w_strb[0]) begin
                    next_control[7:0] = w_data[7:0] & CONTROL_WMASK[7:0];
                end
                if (w_strb[1]) begin
                    next_control[15:8] = w_data[15:8] & CONTROL_WMASK[15:8];
                end
            end else if (aw_addr == {1'b0, ADDR_COUNT}) begin
                if (w_strb[0]) begin
                    next_count[7:0] = w_data[7:0];
                end
                if (w_strb[1]) begin
                    next_count[15:8] = w_data[15:8];
                end
            end else if (aw_addr == {1'b0, ADDR_PERIOD}) begin
                if (w_strb[0]) begin
                    next_period[7:0] = w_data[7:0];
                end
                if (w_strb[1]) begin
                    next_period[15:8] = w_data[15:8];
                end
            end else if (aw_addr == {1'b0, ADDR_STATUS}) begin
                if (w_strb[0]) begin
                    next_status = status & ~w_data[1:0];
                end
            end else if (aw_addr == ADDR_MASK) begin
                if (w_strb[0]) begin
                    next_mask = w_data[1:0];
                end
            end else begin
                next_bresp = RESP_SLVERR;
            end
        end
        // events win over a clear in the same cycle
        if (period_hit) begin
            next_status[IRQ_PERIOD] = 1'b1;
        end
        if (gate_fall) begin
            next_status[IRQ_GATE] = 1'b1;
        end
        if (S_AXI_RVALID && S_AXI_RREADY) begin
            next_rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID) begin
            next_arready = 1'b1;
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0000_0000;
            if (S_AXI_ARADDR == {1'b0, ADDR_CONTROL}) begin
                next_rdata[15:0] = timer_control;
            end else if (S_AXI_ARADDR == {1'b0, ADDR_COUNT}) begin
                next_rdata[15:0] = count;
            end else if (S_AXI_ARADDR == {1'b0, ADDR_PERIOD}) begin
                next_rdata[15:0] = period_register;
            end else if (S_AXI_ARADDR == {1'b0, ADDR_STATUS}) begin
                next_rdata[1:0] = status;
            end else if (S_AXI_ARADDR == ADDR_MASK) begin
                next_rdata[1:0] = mask;
            end else begin
                next_rresp = RESP_SLVERR;
            end
        end
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            timer_control <= CONTROL_RESET;
            count <= 16'h0000;
            period_register <= PERIOD_RESET;
            status <= 2'h0;
            mask <= 2'h0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 5'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= RESP_OKAY;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            IRQ <= 1'b0;
            pin_q <= 1'b0;
            xtal_q <= 1'b0;
            gate_prev <= 1'b0;
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            timer_control <= next_control;
            count <= next_count;
            period_register <= next_period;
            status <= next_status;
            mask <= next_mask;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            S_AXI_BVALID <= next_bvalid;
            S_AXI_BRESP <= next_bresp;
            S_AXI_RVALID <= next_rvalid;
            S_AXI_RDATA <= next_rdata;
            S_AXI_RRESP <= next_rresp;
            S_AXI_ARREADY <= next_arready;
            S_AXI_AWREADY <= ~next_aw_held & ~(S_AXI_AWVALID & S_AXI_AWREADY);
            S_AXI_WREADY <= ~next_w_held & ~(S_AXI_WVALID & S_AXI_WREADY);
            IRQ <= next_irq;
            pin_q <= EXT_COUNT_PIN;
            xtal_q <= CRYSTAL_CLK;
            gate_prev <= EXT_COUNT_PIN;
            // pulse stretched to a level toggle for the synchroniser
            sync_a <= sync_a ^ ps_pulse;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end
endmodule : rtct_timer

/* File: rtct_checker.sv */
// bus and register checks for the timer block
`timescale 1ns/10ps
module rtct_checker import rtct_pkg::*; (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [4:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY
);
    default clocking dc @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    sequence s_rd;
        S_AXI_RVALID && S_AXI_ARREADY;
    endsequence
    sequence s_rd_soon;
        ##[1:2] s_rd;
    endsequence
    property p_rd_width;
        s_rd |-> S_AXI_RDATA[31:16] == 16'h0000;
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("upper data not zero");
    property p_ctl_zero;
        s_rd ##0 S_AXI_ARADDR == 5'h00 |-> (S_AXI_RDATA[15:0] & 16'h5F89) == 16'h0000;
    endproperty
    a_ctl_zero: assert property (p_ctl_zero) else $error("unused control bit set");
    property p_rd_err;
        s_rd ##0 (S_AXI_ARADDR > 5'h10 || S_AXI_ARADDR[1:0] != 2'h0) |->
            S_AXI_RRESP == RESP_SLVERR;
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
    property p_rd_ok;
        s_rd ##0 (S_AXI_ARADDR <= 5'h10 && S_AXI_ARADDR[1:0] == 2'h0) |->
            S_AXI_RRESP == RESP_OKAY;
    endproperty
    a_rd_ok: assert property (p_rd_ok) else $error("mapped read refused");
    property p_rd_answer;
        S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID |-> s_rd_soon;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_ar_pulse;
        S_AXI_ARREADY |=> !S_AXI_ARREADY;
    endproperty
    a_ar_pulse: assert property (p_ar_pulse) else $error("arready too long");
    property p_r_done;
        S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
    endproperty
    a_r_done: assert property (p_r_done) else $error("rvalid after handshake");
    property p_b_done;
        S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
    endproperty
    a_b_done: assert property (p_b_done) else $error("bvalid after handshake");
endmodule : rtct_checker

bind rtct_timer rtct_checker u_chk (.MCLK(MCLK), .RST_N(RST_N),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY));

/* File: rtct_pin_model.sv */
// far side: count pin, gate level and crystal
`timescale 1ns/10ps
module rtct_pin_model (
    output logic pin,
    output logic xtal
);
    initial begin
        pin = 1'h0;
        xtal = 1'h0;
    end
    task automatic edges(input int n, input int hp, input bit x);
        #7;
        repeat (n) begin
            if (x) xtal = 1'h1;
            else pin = 1'h1;
            #(hp);
            if (x) xtal = 1'h0;
            else pin = 1'h0;
            #(hp);
        end
    endtask : edges
    task automatic gate(input bit lvl);
        pin <= lvl;
    endtask : gate
endmodule : rtct_pin_model

/* File: tb_top.sv */
// self-checking bench for the 16-bit timer block
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic idle = 1'h0;
    logic awv = 1'h0, wv = 1'h0, arv = 1'h0;
    logic [4:0] awa = 5'h00, ara = 5'h00;
    logic [31:0] wd = 32'h0, rdata, got;
    logic awr, wrdy, bv, arr, rv, irq, pin, xtal;
    logic [1:0] br, rr, resp;
    logic bready = 1'h0;
    logic rready = 1'h0;
    logic [3:0] ws = 4'hF;
    int error_cnt = 0;
    int checks = 0;
    int i;
    int dv[4] = '{1, 8, 64, 256};
    always #25 clk = ~clk;
    rtct_pin_model pm (.pin(pin), .xtal(xtal));
    rtct_timer dut (
        .MCLK(clk), .RST_N(rst_n), .IDLE(idle), .EXT_COUNT_PIN(pin), .CRYSTAL_CLK(xtal),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(br),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rready), .IRQ(irq)
    );
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic tmo(input int n);
        if (n >= 60) begin
            error_cnt++;
            $display("[ERR] handshake exp answer got none");
            end_of_test();
        end
    endtask : tmo
    task automatic axw(input logic [4:0] a, input logic [31:0] d);
        int n;
        logic ta, tw;
        n = 0;
        ta = 1'h0;
        tw = 1'h0;
        awa <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        while (!(ta && tw) && n < 60) begin
            @(posedge clk);
            n++;
            if (awr && !ta) begin
                ta = 1'h1;
                awv <= 1'h0;
            end
            if (wrdy && !tw) begin
                tw = 1'h1;
                wv <= 1'h0;
            end
        end
        bready <= 1'h1;
        while (!bv && n < 60) begin
            @(posedge clk);
            n++;
        end
        bready <= 1'h0;
        resp = br;
        tmo(n);
    endtask : axw
    task automatic axr(input logic [4:0] a);
        int n;
        n = 0;
        @(posedge clk);
        ara <= a;
        arv <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (arr) arv <= 1'h0;
        end while (!rv && n < 60);
        got = rdata;
        rready <= 1'h0;
        resp = rr;
        tmo(n);
    endtask : axr
    task automatic rc(input string nm, input logic [4:0] a, input logic [31:0] e);
        axr(a);
        chk(nm, e, got);
    endtask : rc
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        cyc(4);
        for (i = 0; i < 5; i++) rc("reset", 5'(i * 4), i == 2 ? 32'hFFFF : 32'h0);
        ws <= 4'h1;
        axw(5'h08, 32'h1234);
        ws <= 4'hF;
        rc("strobe", 5'h08, 32'hFF34);
        axw(5'h00, 32'hFFFFFFFF);
        rc("control", 5'h00, 32'hA076);
        axw(5'h00, 32'h0);
        axr(5'h1C);
        chk("rresp", 32'h2, {30'h0, resp});
        axw(5'h14, 32'h1);
        chk("bresp", 32'h2, {30'h0, resp});
        for (i = 0; i < 4; i++) begin
            axw(5'h04, 32'h0);
            axw(5'h00, 32'h8006 | 32'(i << 4));
            pm.edges(2 * dv[i], 105, 1'h0);
            cyc(6);
            rc("prescaled", 5'h04, 32'h2);
            axw(5'h00, 32'h0);
        end
        axw(5'h04, 32'h0);
        axw(5'h00, 32'h8002);
        pm.edges(3, 255, 1'h1);
        cyc(6);
        rc("async", 5'h04, 32'h3);
        axw(5'h00, 32'h0);
        axw(5'h04, 32'h0);
        axw(5'h10, 32'h2);
        axw(5'h00, 32'h8040);
        cyc(20);
        rc("gate low", 5'h04, 32'h0);
        pm.gate(1'h1);
        cyc(40);
        pm.gate(1'h0);
        cyc(6);
        axr(5'h04);
        chk("gated", 32'h1, 32'(got >= 32'h24 && got <= 32'h2C));
        rc("status", 5'h0C, 32'h2);
        chk("irq", 32'h1, {31'h0, irq});
        axw(5'h0C, 32'h2);
        axw(5'h00, 32'h0);
        axw(5'h04, 32'h0);
        axw(5'h00, 32'h8046);
        pm.gate(1'h1);
        cyc(20);
        pm.gate(1'h0);
        cyc(6);
        rc("gate ignored", 5'h04, 32'h1);
        rc("no gate flag", 5'h0C, 32'h0);
        chk("irq off", 32'h0, {31'h0, irq});
        axw(5'h00, 32'h0);
        axw(5'h04, 32'h0);
        axw(5'h08, 32'h4);
        axw(5'h10, 32'h1);
        axw(5'h00, 32'h8000);
        cyc(20);
        axw(5'h00, 32'h0);
        rc("match", 5'h0C, 32'h1);
        axr(5'h04);
        chk("wrap", 32'h1, 32'(got <= 32'h4));
        axw(5'h04, 32'h5);
        cyc(10);
        rc("stopped", 5'h04, 32'h5);
        chk("irq", 32'h1, {31'h0, irq});
        axw(5'h10, 32'h0);
        cyc(2);
        chk("masked", 32'h0, {31'h0, irq});
        axw(5'h0C, 32'h1);
        rc("cleared", 5'h0C, 32'h0);
        axw(5'h08, 32'hFFFF);
        axw(5'h04, 32'h0);
        idle <= 1'h1;
        axw(5'h00, 32'hA000);
        cyc(20);
        rc("idle stop", 5'h04, 32'h0);
        axw(5'h00, 32'h8000);
        cyc(20);
        axw(5'h00, 32'h0);
        axr(5'h04);
        chk("idle run", 32'h1, 32'(got >= 32'h14));
        end_of_test();
    end
endmodule : tb_top
